// File: inc/crqm_pkg.sv
// constants shared by the receive queue and match block
package crqm_pkg;
	// ----------------------------------------------------------------
	// sizes
	// ----------------------------------------------------------------
	localparam int QDEPTH = 6;
	localparam int NMB = 32;
	localparam int NFILT = 32;
	localparam logic [2:0] WARN_FROM = 3'h4;
	localparam logic [2:0] LAST_SLOT = 3'h5;
	// ----------------------------------------------------------------
	// register byte offsets
	// ----------------------------------------------------------------
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_STAT = 8'h04;
	localparam logic [7:0] OFS_INTEN = 8'h08;
	localparam logic [7:0] OFS_FIDX = 8'h0C;
	localparam logic [7:0] OFS_WORD0 = 8'h10;
	localparam logic [7:0] OFS_WORD1 = 8'h14;
	localparam logic [7:0] OFS_WORD2 = 8'h18;
	localparam logic [7:0] OFS_WORD3 = 8'h1C;
	// ----------------------------------------------------------------
	// field positions
	// ----------------------------------------------------------------
	localparam int B_QEN = 0;
	localparam int B_DREQ = 1;
	localparam int B_PRIV = 2;
	localparam int B_ORDER = 3;
	localparam int B_RRS = 4;
	localparam int B_FCNT = 8;
	localparam int B_SLOT0 = 0;
	localparam int B_NE = 5;
	localparam int B_WARN = 6;
	localparam int B_OVF = 7;
	// ----------------------------------------------------------------
	// reset values
	// ----------------------------------------------------------------
	localparam logic [31:0] RST_CTRL = 32'h0000_0000;
	localparam logic [31:0] RST_INTEN = 32'h0000_0000;
endpackage

// File: hdl/crqm_qmem.sv
// six-entry storage of queued frames with registered read data
`timescale 1ns/1ps
module crqm_qmem (
	// clock
	input wire logic clk_i,
	// write side
	input wire logic we_i,
	input wire logic [2:0] wa_i,
	input wire logic [132:0] wd_i,
	// read side
	input wire logic [2:0] ra_i,
	output logic [132:0] rd_o
);
	logic [132:0] mem [crqm_pkg::QDEPTH];
	logic [132:0] next_rd;

	always_comb begin
		next_rd = mem[ra_i];
		// write-first so a frame landing in an empty queue is visible at once
		if (we_i && (wa_i == ra_i)) begin
			next_rd = wd_i;
		end
	end

	always_ff @(posedge clk_i) begin
		if (we_i) begin
			mem[wa_i] <= wd_i;
		end
		rd_o <= next_rd;
	end
endmodule

// File: hdl/crqm_match.sv
// combinational winner search between mailboxes and the queue
`timescale 1ns/1ps
module crqm_match (
	// configuration
	input wire logic qen_i,
	input wire logic priv_i,
	input wire logic order_i,
	input wire logic rrs_i,
	input wire logic [3:0] fcnt_i,
	// frame and queue state
	input wire logic rtr_i,
	input wire logic qfull_i,
	// mailbox state
	input wire logic [31:0] mb_hit_i,
	input wire logic [31:0] mb_empty_i,
	input wire logic [31:0] mb_full_i,
	input wire logic [31:0] mb_serviced_i,
	input wire logic [31:0] mb_answer_i,
	// queue filter hits
	input wire logic [31:0] qf_priv_hit_i,
	input wire logic [31:0] qf_shared_hit_i,
	// result
	output logic mb_win_o,
	output logic [4:0] mb_idx_o,
	output logic mb_overrun_o,
	output logic q_win_o,
	output logic q_ovf_o,
	output logic [4:0] fidx_o
);
	logic [31:0] free;
	logic [31:0] qhit;
	logic [5:0] nf;
	logic any_free, any_hit, q_match, q_ok, mb_valid;
	logic [4:0] first_any, first_free, last_busy;

	always_comb begin
		// free-to-receive depends on frame type and remote store select
		free = (rtr_i && !rrs_i) ? mb_answer_i : (mb_empty_i | (mb_full_i & mb_serviced_i)); // (R22)
		nf = {1'b0, fcnt_i, 1'b0} + 6'h02; // (R3)
		qhit = priv_i ? qf_priv_hit_i : qf_shared_hit_i; // (R4)
		any_free = 1'b0;
		any_hit = 1'b0;
		q_match = 1'b0;
		first_any = 5'h00;
		first_free = 5'h00;
		last_busy = 5'h00;
		fidx_o = 5'h00;
		for (int i = crqm_pkg::NMB - 1; i >= 0; i--) begin
			if (mb_hit_i[i]) begin
				first_any = 5'(i);
				any_hit = 1'b1;
			end
			if (mb_hit_i[i] && free[i]) begin
				first_free = 5'(i);
				any_free = 1'b1;
			end
			if (qhit[i] && (6'(i) < nf)) begin
				fidx_o = 5'(i);
				q_match = 1'b1;
			end
		end
		for (int i = 0; i < crqm_pkg::NMB; i++) begin
			if (mb_hit_i[i] && !free[i]) begin
				last_busy = 5'(i);
			end
		end
		mb_valid = any_hit;
		mb_idx_o = priv_i ? (any_free ? first_free : last_busy) : first_any; // (R17) (R20)
		mb_overrun_o = !free[mb_idx_o]; // (R18)
		q_ok = qen_i && q_match && !qfull_i; // (R21)
		if (qen_i && !order_i) begin
			q_win_o = q_ok; // (R20)
			mb_win_o = !q_ok && mb_valid;
		end else begin
			mb_win_o = mb_valid && !(priv_i && !any_free && q_ok); // (R17) (R18)
			q_win_o = !mb_win_o && q_ok; // (R19)
		end
		q_ovf_o = qen_i && q_match && qfull_i && !mb_win_o; // (R19)
	end
endmodule

// File: hdl/crqm_top.sv
// receive queue, its register view and the receive matching search
//
// The implementer's own choices: the address map and the Wishbone interface to the registers.
`timescale 1ns/1ps
// Operation
// (R1) queue holds six frames while enabled
// (R2) software keeps queue off in fd mode
// (R3) filter count field sets active filters
// (R4) private bit selects per-entry or shared filtering
// (R5) not-empty flag marks valid output words
// (R6) flag raises interrupt, or dma request
// (R7) cpu clear advances queue, flag stays
// (R8) dma read of word three advances
// (R9) dma reads filter index before word three
// (R10) dma mode needs enable and dma bits
// (R11) warning and overflow silent in dma mode
// (R12) software drains queue before dma enable
// (R13) clear withdraws flag and dma request
// (R14) slot-zero write empties queue when inactive
// (R15) warning at four to five, overflow on loss
// (R16) search starts after length code field
// (R17) order one searches mailboxes first
// (R18) busy-only match prefers free queue
// (R19) no mailbox match tries the queue
// (R20) order zero tries queue first
// (R21) disabled queue leaves mailboxes only
// (R22) free mailbox depends on frame type
// (R23) last message clear empties output words
module crqm_top (
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// wishbone slave
	input wire logic [7:0] wb_adr_i,
	input wire logic [31:0] wb_dat_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic wb_we_i,
	input wire logic wb_stb_i,
	input wire logic wb_cyc_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	// controller state
	input wire logic ctrl_inactive_i,
	// received frame
	input wire logic match_start_i,
	input wire logic frame_rtr_i,
	input wire logic shift_in_i,
	input wire logic [31:0] frame_word0_i,
	input wire logic [31:0] frame_word1_i,
	input wire logic [31:0] frame_word2_i,
	input wire logic [31:0] frame_word3_i,
	// mailbox and filter results
	input wire logic [31:0] mb_hit_i,
	input wire logic [31:0] mb_empty_i,
	input wire logic [31:0] mb_full_i,
	input wire logic [31:0] mb_serviced_i,
	input wire logic [31:0] mb_answer_i,
	input wire logic [31:0] qf_priv_hit_i,
	input wire logic [31:0] qf_shared_hit_i,
	// search result and requests
	output logic mbx_win_o,
	output logic [4:0] mbx_win_idx_o,
	output logic mbx_overrun_o,
	output logic queue_irq_o,
	output logic dma_req_o
);
	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	logic [31:0] ctrl, next_ctrl;
	logic [31:0] inten, next_inten;
	logic [2:0] wr_ptr, next_wr_ptr;
	logic [2:0] rd_ptr, next_rd_ptr;
	logic [2:0] count, next_count;
	logic ne, next_ne;
	logic warn, next_warn;
	logic ovf, next_ovf;
	logic q_pend, next_q_pend;
	logic [4:0] pend_fidx, next_pend_fidx;
	logic ack, next_ack;
	logic [31:0] dat, next_dat;
	logic win, next_win;
	logic [4:0] win_idx, next_win_idx;
	logic overrun, next_overrun;
	logic irq, next_irq;
	logic dreq, next_dreq;
	logic [132:0] rd_word;
	logic m_mb, m_ovr, m_q, m_qovf;
	logic [4:0] m_idx, m_fidx;
	logic wb_go, wr_stat, clr_ne, slot0, dma_mode, push, pop, qfull, advance;

	// ----------------------------------------------------------------
	// storage and search
	// ----------------------------------------------------------------
	crqm_qmem u_mem (
		.clk_i(clk_i),
		.we_i(push),
		.wa_i(wr_ptr),
		.wd_i({pend_fidx, frame_word3_i, frame_word2_i, frame_word1_i, frame_word0_i}),
		.ra_i(rd_ptr),
		.rd_o(rd_word)
	);

	crqm_match u_match (
		.qen_i(ctrl[crqm_pkg::B_QEN]),
		.priv_i(ctrl[crqm_pkg::B_PRIV]),
		.order_i(ctrl[crqm_pkg::B_ORDER]),
		.rrs_i(ctrl[crqm_pkg::B_RRS]),
		.fcnt_i(ctrl[crqm_pkg::B_FCNT +: 4]),
		.rtr_i(frame_rtr_i),
		.qfull_i(qfull),
		.mb_hit_i(mb_hit_i),
		.mb_empty_i(mb_empty_i),
		.mb_full_i(mb_full_i),
		.mb_serviced_i(mb_serviced_i),
		.mb_answer_i(mb_answer_i),
		.qf_priv_hit_i(qf_priv_hit_i),
		.qf_shared_hit_i(qf_shared_hit_i),
		.mb_win_o(m_mb),
		.mb_idx_o(m_idx),
		.mb_overrun_o(m_ovr),
		.q_win_o(m_q),
		.q_ovf_o(m_qovf),
		.fidx_o(m_fidx)
	);

	// ----------------------------------------------------------------
	// bus decode and queue control
	// ----------------------------------------------------------------
	always_comb begin
		dma_mode = ctrl[crqm_pkg::B_QEN] && ctrl[crqm_pkg::B_DREQ]; // (R10)
		qfull = (count == 3'(crqm_pkg::QDEPTH)); // (R1)
		wb_go = wb_cyc_i && wb_stb_i && !ack;
		wr_stat = wb_go && wb_we_i && (wb_adr_i == crqm_pkg::OFS_STAT) && wb_sel_i[0];
		slot0 = wr_stat && wb_dat_i[crqm_pkg::B_SLOT0] && ctrl[crqm_pkg::B_QEN]
			&& ctrl_inactive_i; // (R14)
		// cpu clears the flag outside dma mode, dma read of word three inside
		clr_ne = ((wr_stat && wb_dat_i[crqm_pkg::B_NE] && !dma_mode)
			|| (wb_go && !wb_we_i && (wb_adr_i == crqm_pkg::OFS_WORD3) && dma_mode))
			&& ne; // (R7) (R8)
		pop = clr_ne && (count != 3'h0) && !slot0;
		advance = pop && (count > 3'h1);
		push = shift_in_i && q_pend && !slot0; // (R1)
	end

	always_comb begin
		next_wr_ptr = wr_ptr;
		next_rd_ptr = rd_ptr;
		next_count = count;
		next_ne = ne;
		next_warn = warn;
		next_ovf = ovf;
		next_q_pend = q_pend;
		next_pend_fidx = pend_fidx;
		if (push) begin
			next_wr_ptr = (wr_ptr == crqm_pkg::LAST_SLOT) ? 3'h0 : wr_ptr + 3'h1;
		end
		if (pop) begin
			next_rd_ptr = (rd_ptr == crqm_pkg::LAST_SLOT) ? 3'h0 : rd_ptr + 3'h1; // (R7) (R8)
		end
		next_count = count + (push ? 3'h1 : 3'h0) - (pop ? 3'h1 : 3'h0);
		if (slot0) begin
			next_wr_ptr = 3'h0;
			next_rd_ptr = 3'h0;
			next_count = 3'h0; // (R14)
			next_q_pend = 1'b0;
		end
		if (clr_ne) begin
			next_ne = advance; // (R23)
		end
		if (slot0 && dma_mode) begin
			next_ne = 1'b0; // (R13)
		end
		// a landing frame wins over a cpu or dma clear in the same cycle; a slot-zero write drops it
		if (push) begin
			next_ne = 1'b1; // (R5)
		end
		if (wr_stat && wb_dat_i[crqm_pkg::B_WARN]) begin
			next_warn = 1'b0;
		end
		if (wr_stat && wb_dat_i[crqm_pkg::B_OVF]) begin
			next_ovf = 1'b0;
		end
		if (push && (count == crqm_pkg::WARN_FROM) && !pop && !dma_mode) begin
			next_warn = 1'b1; // (R15) (R11)
		end
		if (shift_in_i) begin
			next_q_pend = 1'b0;
		end
		// the search result is held until the shift-in moment
		if (match_start_i) begin
			next_q_pend = m_q; // (R16)
			next_pend_fidx = m_fidx;
			if (m_qovf && !dma_mode) begin
				next_ovf = 1'b1; // (R15) (R11)
			end
		end
		if (!ctrl[crqm_pkg::B_QEN]) begin
			next_q_pend = 1'b0; // (R1)
		end
	end

	// ----------------------------------------------------------------
	// registers, outputs and read data
	// ----------------------------------------------------------------
	always_comb begin
		next_ctrl = ctrl;
		next_inten = inten;
		next_ack = wb_go;
		next_dat = 32'h0000_0000;
		if (wb_go && wb_we_i) begin
			for (int b = 0; b < 4; b++) begin
				if (wb_sel_i[b] && (wb_adr_i == crqm_pkg::OFS_CTRL)) begin
					next_ctrl[8*b +: 8] = wb_dat_i[8*b +: 8];
				end
				if (wb_sel_i[b] && (wb_adr_i == crqm_pkg::OFS_INTEN)) begin
					next_inten[8*b +: 8] = wb_dat_i[8*b +: 8];
				end
			end
		end
		if (wb_go && !wb_we_i) begin
			case (wb_adr_i)
				crqm_pkg::OFS_CTRL: begin
					next_dat = ctrl;
				end
				crqm_pkg::OFS_STAT: begin
					next_dat[crqm_pkg::B_NE] = ne;
					next_dat[crqm_pkg::B_WARN] = warn && !dma_mode; // (R11)
					next_dat[crqm_pkg::B_OVF] = ovf && !dma_mode;
				end
				crqm_pkg::OFS_INTEN: begin
					next_dat = inten;
				end
				crqm_pkg::OFS_FIDX: begin
					next_dat = {27'h000_0000, rd_word[132:128]};
				end
				crqm_pkg::OFS_WORD0: begin
					next_dat = rd_word[31:0];
				end
				crqm_pkg::OFS_WORD1: begin
					next_dat = rd_word[63:32];
				end
				crqm_pkg::OFS_WORD2: begin
					next_dat = rd_word[95:64];
				end
				crqm_pkg::OFS_WORD3: begin
					next_dat = rd_word[127:96];
				end
				default: begin
					next_dat = 32'h0000_0000;
				end
			endcase
		end
		// outputs drop for the advance cycle so each message gives a fresh request
		next_irq = next_ne && !pop && inten[crqm_pkg::B_NE] && !dma_mode; // (R6)
		next_dreq = next_ne && !pop && dma_mode; // (R6) (R8) (R13)
		next_win = match_start_i && m_mb; // (R21)
		next_win_idx = match_start_i ? m_idx : win_idx;
		next_overrun = match_start_i && m_mb && m_ovr; // (R18)
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ctrl <= crqm_pkg::RST_CTRL;
			inten <= crqm_pkg::RST_INTEN;
			wr_ptr <= 3'h0;
			rd_ptr <= 3'h0;
			count <= 3'h0;
			ne <= 1'b0;
			warn <= 1'b0;
			ovf <= 1'b0;
			q_pend <= 1'b0;
			pend_fidx <= 5'h00;
			ack <= 1'b0;
			dat <= 32'h0000_0000;
			win <= 1'b0;
			win_idx <= 5'h00;
			overrun <= 1'b0;
			irq <= 1'b0;
			dreq <= 1'b0;
		end else begin
			ctrl <= next_ctrl;
			inten <= next_inten;
			wr_ptr <= next_wr_ptr;
			rd_ptr <= next_rd_ptr;
			count <= next_count;
			ne <= next_ne;
			warn <= next_warn;
			ovf <= next_ovf;
			q_pend <= next_q_pend;
			pend_fidx <= next_pend_fidx;
			ack <= next_ack;
			dat <= next_dat;
			win <= next_win;
			win_idx <= next_win_idx;
			overrun <= next_overrun;
			irq <= next_irq;
			dreq <= next_dreq;
		end
	end

	assign wb_ack_o = ack;
	assign wb_dat_o = dat;
	assign mbx_win_o = win;
	assign mbx_win_idx_o = win_idx;
	assign mbx_overrun_o = overrun;
	assign queue_irq_o = irq;
	assign dma_req_o = dreq;

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	property p_depth;
		@(posedge clk_i) disable iff (rst_i) count <= 3'(crqm_pkg::QDEPTH);
	endproperty
	a_depth: assert property (p_depth) else $error("queue count above six"); // (R1)

	property p_ne_count;
		@(posedge clk_i) disable iff (rst_i) (count != 3'h0) |-> ne;
	endproperty
	a_ne_count: assert property (p_ne_count) else $error("frames queued but flag clear"); // (R5)

	property p_irq_dma;
		@(posedge clk_i) disable iff (rst_i) dma_mode |-> ##1 !irq;
	endproperty
	a_irq_dma: assert property (p_irq_dma) else $error("queue interrupt in dma mode"); // (R6)

	property p_advance;
		@(posedge clk_i) disable iff (rst_i)
			(advance && !push) |=> (ne && count == $past(count) - 3'h1);
	endproperty
	a_advance: assert property (p_advance) else $error("advance lost flag or count"); // (R7)

	property p_last;
		@(posedge clk_i) disable iff (rst_i)
			(pop && count == 3'h1 && !push) |=> (!ne && count == 3'h0);
	endproperty
	a_last: assert property (p_last) else $error("last pop left queue valid"); // (R23)

	property p_dma_clear;
		@(posedge clk_i) disable iff (rst_i) (slot0 && dma_mode && !push) |=> ##1 !dreq;
	endproperty
	a_dma_clear: assert property (p_dma_clear) else $error("dma request after clear"); // (R13)

	property p_warn;
		@(posedge clk_i) disable iff (rst_i)
			(push && !pop && count == 3'h4 && !dma_mode) |=> (warn && count == 3'h5);
	endproperty
	a_warn: assert property (p_warn) else $error("warning not set at five"); // (R15)

	property p_silent;
		@(posedge clk_i) disable iff (rst_i) (dma_mode && !warn) |=> !warn;
	endproperty
	a_silent: assert property (p_silent) else $error("warning raised in dma mode"); // (R11)

	property p_no_qwin;
		@(posedge clk_i) disable iff (rst_i) !ctrl[crqm_pkg::B_QEN] |=> !push;
	endproperty
	a_no_qwin: assert property (p_no_qwin) else $error("push with queue disabled"); // (R21)
endmodule

// File: sim/crqm_far.sv
// far-side model: other bus nodes delivering received frames and compare results
`timescale 1ns/1ps
module crqm_far (
	// clock
	input wire logic clk_i,
	// frame timing
	output logic match_start_i,
	output logic frame_rtr_i,
	output logic shift_in_i,
	// frame words
	output logic [31:0] frame_word0_i,
	output logic [31:0] frame_word1_i,
	output logic [31:0] frame_word2_i,
	output logic [31:0] frame_word3_i,
	// compare results
	output logic [31:0] mb_hit_i,
	output logic [31:0] mb_empty_i,
	output logic [31:0] mb_full_i,
	output logic [31:0] mb_serviced_i,
	output logic [31:0] mb_answer_i,
	output logic [31:0] qf_priv_hit_i,
	output logic [31:0] qf_shared_hit_i
);
	initial begin
		{match_start_i, frame_rtr_i, shift_in_i} = 3'h0;
		{frame_word3_i, frame_word2_i, frame_word1_i, frame_word0_i} = '0;
		{mb_hit_i, mb_empty_i, mb_full_i, mb_serviced_i, mb_answer_i} = '0;
		{qf_priv_hit_i, qf_shared_hit_i} = '0;
	end
	// ----------------------------------------------------------------
	// one classical frame; lines not sampled show inverted junk
	// ----------------------------------------------------------------
	task send(input logic [31:0] mh, me, mf, ms, mr, qp, qs, input logic r,
		input logic [127:0] w, input int g);
		@(posedge clk_i);
		match_start_i <= 1'b1;
		frame_rtr_i <= r;
		{mb_hit_i, mb_empty_i, mb_full_i, mb_serviced_i} <= {mh, me, mf, ms};
		{mb_answer_i, qf_priv_hit_i, qf_shared_hit_i} <= {mr, qp, qs};
		@(posedge clk_i);
		match_start_i <= 1'b0;
		frame_rtr_i <= ~r;
		{mb_hit_i, mb_empty_i, mb_full_i, mb_serviced_i} <= ~{mh, me, mf, ms};
		{mb_answer_i, qf_priv_hit_i, qf_shared_hit_i} <= ~{mr, qp, qs};
		repeat (g) @(posedge clk_i);
		shift_in_i <= 1'b1;
		{frame_word3_i, frame_word2_i, frame_word1_i, frame_word0_i} <= w;
		@(posedge clk_i);
		shift_in_i <= 1'b0;
		{frame_word3_i, frame_word2_i, frame_word1_i, frame_word0_i} <= ~w;
	endtask
endmodule

// File: sim/tb.sv
// self-checking bench for the receive queue and match block
`timescale 1ns/1ps
module tb;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic [7:0] wb_adr_i = 8'h0;
	logic [31:0] wb_dat_i = 32'h0;
	logic [3:0] wb_sel_i = 4'hf;
	logic wb_we_i = 1'b0;
	logic wb_stb_i = 1'b0;
	logic wb_cyc_i = 1'b0;
	logic ctrl_inactive_i = 1'b0;
	logic match_start_i, frame_rtr_i, shift_in_i;
	logic [31:0] frame_word0_i, frame_word1_i, frame_word2_i, frame_word3_i;
	logic [31:0] mb_hit_i, mb_empty_i, mb_full_i, mb_serviced_i, mb_answer_i;
	logic [31:0] qf_priv_hit_i, qf_shared_hit_i, wb_dat_o;
	logic [4:0] mbx_win_idx_o;
	logic wb_ack_o, mbx_win_o, mbx_overrun_o, queue_irq_o, dma_req_o;
	logic [31:0] eq[$];
	logic [31:0] mq[$];
	logic [132:0] fq[$];
	int n_mismatch = 0;
	int checked = 0;
	int seed = 87;

	always #5 clk_i = ~clk_i;

	crqm_top crqm_top_i (.*);
	crqm_far crqm_far_i (.*);

	// ----------------------------------------------------------------
	// checking and closing
	// ----------------------------------------------------------------
	task chk(input string n, input logic [31:0] s, e);
		checked++;
		if (s !== e) begin
			n_mismatch++;
			$display("[FAIL] %s exp %h got %h", n, e, s);
		end
	endtask

	task stop_test;
		if (n_mismatch == 0 && checked > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	always @(posedge clk_i) begin
		if (wb_ack_o === 1'b1 && wb_we_i === 1'b0)
			chk("wb_dat_o", wb_dat_o, eq.pop_front());
		if (mbx_win_o !== 1'b0) begin
			chk("mbx_win_due", mq.size() != 0, 32'h1);
			chk("mbx_win", {mbx_overrun_o, mbx_win_idx_o}, mq.pop_front());
		end
	end

	// ----------------------------------------------------------------
	// bus and frame tasks
	// ----------------------------------------------------------------
	task cyc(input int k);
		repeat (k) @(posedge clk_i);
	endtask

	task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_i);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= w;
		wb_adr_i <= a;
		wb_dat_i <= d;
		for (int n = 0; wb_ack_o !== 1'b1; n++) begin
			if (n == 20) begin
				n_mismatch++;
				stop_test();
			end
			@(posedge clk_i);
		end
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
	endtask

	task rd(input logic [7:0] a, input logic [31:0] e);
		eq.push_back(e);
		wb(1'b0, a, 32'h0);
	endtask

	task wr(input logic [7:0] a, input logic [31:0] d);
		wb(1'b1, a, d);
	endtask

	task fr(input logic [31:0] mh, me, mf, ms, mr, qp, qs, input logic r, input int st, mb);
		logic [127:0] w;
		w = {$random(seed), $random(seed), $random(seed), $random(seed)};
		if (mb >= 0)
			mq.push_back(mb);
		if (st >= 0)
			fq.push_back({st[4:0], w});
		crqm_far_i.send(mh, me, mf, ms, mr, qp, qs, r, w, 1 + ($random(seed) & 3));
		cyc(2);
	endtask

	task head(input logic dma);
		logic [132:0] h;
		h = fq.pop_front();
		rd(8'h0c, {27'h0, h[132:128]});
		rd(8'h10, h[31:0]);
		rd(8'h14, h[63:32]);
		rd(8'h18, h[95:64]);
		rd(8'h1c, h[127:96]);
		if (!dma)
			wr(8'h04, 32'h20);
		cyc(3);
		chk("queue_irq_o", queue_irq_o, !dma && fq.size() != 0);
		chk("dma_req_o", dma_req_o, dma && fq.size() != 0);
	endtask

	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial begin
		cyc(5);
		rst_i <= 1'b0;
		rd(8'h00, crqm_pkg::RST_CTRL);
		rd(8'h08, crqm_pkg::RST_INTEN);
		rd(8'h04, 32'h0);
		rd(8'h20, 32'h0);
		wr(8'h08, 32'h20);
		wr(8'h00, 32'h1);
		fr('0, '0, '0, '0, '0, '0, 32'h4, 1'b0, -1, -1);
		fr('0, '0, '0, '0, '0, 32'h1, '0, 1'b0, -1, -1);
		rd(8'h04, 32'h0);
		for (int i = 0; i < 7; i++) begin
			fr(i < 6 ? 32'h10 : 32'h0, 32'h10, '0, '0, '0, '0, 32'h2, 1'b0, i < 6 ? 1 : -1, -1);
			if (i == 4)
				rd(8'h04, 32'h60);
		end
		rd(8'h04, 32'he0);
		fr(32'h40, 32'h40, '0, '0, '0, '0, 32'h2, 1'b0, -1, 6);
		chk("queue_irq_o", queue_irq_o, 1'b1);
		repeat (6) head(1'b0);
		rd(8'h04, 32'hc0);
		wr(8'h00, 32'h9);
		fr(32'h28, '0, 32'h28, '0, '0, '0, 32'h2, 1'b0, -1, 35);
		wr(8'h00, 32'hd);
		fr(32'h28, '0, 32'h28, 32'h20, '0, 32'h1, '0, 1'b0, -1, 5);
		fr(32'h88, '0, 32'h88, '0, '0, 32'h1, '0, 1'b0, 0, -1);
		fr(32'h88, '0, 32'h88, '0, '0, '0, '0, 1'b0, -1, 39);
		fr(32'h204, 32'h4, '0, '0, 32'h200, '0, '0, 1'b1, -1, 9);
		wr(8'h00, 32'h1d);
		fr(32'h204, 32'h4, '0, '0, 32'h200, '0, '0, 1'b1, -1, 2);
		fr('0, '0, '0, '0, '0, 32'h2, '0, 1'b0, 1, -1);
		repeat (2) head(1'b0);
		wr(8'h00, 32'h4);
		fr(32'h10, '0, 32'h10, '0, '0, 32'h1, '0, 1'b0, -1, 36);
		rd(8'h04, 32'hc0);
		wr(8'h00, 32'h3);
		fr('0, '0, '0, '0, '0, '0, 32'h1, 1'b0, 0, -1);
		chk("dma_req_o", dma_req_o, 1'b1);
		rd(8'h04, 32'h20);
		wr(8'h04, 32'hc0);
		head(1'b1);
		chk("dma_req_o", dma_req_o, 1'b0);
		repeat (5) fr('0, '0, '0, '0, '0, '0, 32'h2, 1'b0, 1, -1);
		head(1'b1);
		chk("dma_req_o", dma_req_o, 1'b1);
		ctrl_inactive_i <= 1'b1;
		wr(8'h04, 32'h1);
		cyc(2);
		chk("dma_req_o", dma_req_o, 1'b0);
		rd(8'h04, 32'h0);
		fq.delete();
		wr(8'h00, 32'h1);
		rd(8'h04, 32'h0);
		fr('0, '0, '0, '0, '0, '0, 32'h1, 1'b0, 0, -1);
		wr(8'h04, 32'h1);
		rd(8'h04, 32'h20);
		fq.delete();
		wr(8'h04, 32'he0);
		ctrl_inactive_i <= 1'b0;
		rd(8'h04, 32'h0);
		wr(8'h00, 32'h101);
		fr('0, '0, '0, '0, '0, '0, 32'h8, 1'b0, 3, -1);
		head(1'b0);
		chk("mbx_pulses", mq.size(), 32'h0);
		stop_test();
	end
endmodule
